// *** design/counter_pkg.sv ***
// Constants for the gated counter channel: register map, fields, resets and timing.
package counter_pkg;
  localparam int         ADDR_W          = 4;
  localparam int         DATA_W          = 32;
  // Register offsets (word addresses on the plain register port).
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_CFG         = 4'h1;
  localparam logic [3:0] REG_CMP         = 4'h2;
  localparam logic [3:0] REG_COUNT       = 4'h3;
  localparam logic [3:0] REG_LATCH       = 4'h4;
  localparam logic [3:0] REG_STATUS      = 4'h5;
  localparam logic [3:0] REG_EVENT       = 4'h6;
  // Control register fields.
  localparam int         CTRL_SOFT_GATE  = 0;
  localparam int         CTRL_CMP_EN     = 1;
  localparam int         CTRL_PLAIN_OUT  = 2;
  // Configuration register fields.
  localparam int         CFG_FREQ_LSB    = 0;
  localparam int         CFG_LFREQ_LSB   = 2;
  localparam int         CFG_EVAL_LSB    = 4;
  localparam int         CFG_PIN_COUNT_GATE     = 6;
  localparam int         CFG_DIR_INV     = 7;
  localparam int         CFG_CHAR_LSB    = 8;
  localparam int         CFG_IRQ_OPEN    = 10;
  localparam int         CFG_IRQ_CLOSE   = 11;
  localparam int         CFG_IRQ_CMP     = 12;
  localparam int         CFG_IRQ_OFLW    = 13;
  localparam int         CFG_IRQ_UFLW    = 14;
  localparam int         CFG_HYST_LSB    = 16;
  localparam int         CFG_DUR_LSB     = 24;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
  // Status bits.
  localparam int         ST_GATE         = 0;
  localparam int         ST_PIN_GATE     = 1;
  localparam int         ST_LATCH        = 2;
  localparam int         ST_OUT          = 3;
  localparam int         ST_CMP_HIT      = 4;
  localparam int         ST_UP           = 5;
  localparam int         ST_DOWN         = 6;
  // Event bits.
  localparam int         EV_OPEN         = 0;
  localparam int         EV_CLOSE        = 1;
  localparam int         EV_CMP          = 2;
  localparam int         EV_OFLW         = 3;
  localparam int         EV_UFLW         = 4;
  // Timing.
  localparam int         CLK_HZ          = 200_000_000;
  localparam int         TICK_US_NUM     = 1024;
  // One time unit of 1.024 ms: cycles per microsecond times 1024 microseconds.
  localparam int         TICK_CYC        = CLK_HZ / 1_000_000 * TICK_US_NUM;
  localparam int         F10K_HZ         = 10_000;
  localparam int         F5K_HZ          = 5_000;
  localparam int         F2K_HZ          = 2_000;
  localparam int         F1K_HZ          = 1_000;
  // Filter rejects pulses shorter than half the period of the maximum rate.
  localparam int         FLT10_CYC       = CLK_HZ / (2 * F10K_HZ);
  localparam int         FLT5_CYC        = CLK_HZ / (2 * F5K_HZ);
  localparam int         FLT2_CYC        = CLK_HZ / (2 * F2K_HZ);
  localparam int         FLT1_CYC        = CLK_HZ / (2 * F1K_HZ);
  localparam int         HYST_MAX        = 255;
  localparam int         DUR_MAX         = 510;
  typedef enum logic [1:0] {EVAL_PULSE = 2'h0, EVAL_X1 = 2'h1, EVAL_X2 = 2'h2,
                            EVAL_X4 = 2'h3} eval_t;
  typedef enum logic [1:0] {CH_NONE = 2'h0, CH_GE = 2'h1, CH_LE = 2'h2,
                            CH_PULSE = 2'h3} char_t;
  typedef enum logic [2:0] {PS_IDLE = 3'b001, PS_HOLD = 3'b010,
                            PS_DONE = 3'b100} pulse_t;
endpackage

// *** design/gated_counter.sv ***
// Gated counter channel with filtered inputs, comparator output and event flags.
//
// How it works
// RULE_01: Hysteresis 0..255 around compare value; 0 or 1 means off, default 0.
// RULE_02: Count and pin gate inputs filtered to 10, 5, 2 or 1 kHz.
// RULE_03: Latch input filtered separately to 10, 5, 2 or 1 kHz.
// RULE_04: Evaluation: pulse/direction, or quadrature single, double, quadruple edges.
// RULE_05: Hardware gating on uses software and pin gate; off uses software only.
// RULE_06: Direction inversion flips the direction input sense; off by default.
// RULE_07: Output and compare flag follow none, at-or-above, at-or-below or pulse mode.
// RULE_08: Pulse mode holds output duration times 1.024 ms; even 0..510 only.
// RULE_09: Event on pin gate opening while the software gate is open.
// RULE_10: Event on pin gate closing while the software gate is open.
// RULE_11: Event when count reaches the compare value.
// RULE_12: Compare event suppressed when output characteristic is no comparison.
// RULE_13: Event when count passes the upper count limit.
// RULE_14: Event when count passes the lower count limit.
// RULE_15: Software starts and stops counting with the soft gate bit.
// RULE_16: Software enables comparator control or drives output as plain output.
// RULE_17: Count and latched value are readable at any time.
// RULE_18: Register reads and writes from software are always carried out.
// RULE_19: Internal gate combines pin and software gates; pin term ignored if off.
// RULE_20: Pin gate opens on rising and closes on falling edge.
// RULE_21: Pulse mode with zero duration holds output while compare holds.
// RULE_22: Rising latch edge captures the count into the latch register.
// RULE_23: With hysteresis the output holds until count leaves the hysteresis band.
// RULE_24: Filters reject pulses shorter than half the maximum-rate period.
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
module gated_counter
  import counter_pkg::*;
#(
  // Cycles per 1.024 ms unit; a bench may shorten it to keep runs brief.
  parameter int TICK_CYC_P = counter_pkg::TICK_CYC
)
(
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  // Field inputs
  input  wire logic                          track_a_i,
  input  wire logic                          track_b_i,
  input  wire logic                          pin_gate_i,
  input  wire logic                          latch_i,
  // Register port
  input  wire logic [counter_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [counter_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [counter_pkg::DATA_W-1:0] rdata_o,
  // Field output and event flags
  output logic                              count_out_o,
  output logic                              event_o
);
  import counter_pkg::*;

  logic [3:0] sync1_q, sync2_q;
  logic [3:0] flt_q;
  logic [3:0] flt_prev_q;
  logic [16:0] fcnt_q [4];
  logic [16:0] fcnt_d [4];
  logic [3:0] flt_d;
  logic [31:0] ctrl_q, ctrl_d, cfg_q, cfg_d, cmp_q, cmp_d;
  logic signed [31:0] count_q, count_d, latch_q, latch_d;
  logic [DATA_W-1:0] rdata_d;
  logic [4:0] ev_q, ev_d;
  logic out_q, out_d, hit_q, hit_d, up_q, up_d, dn_q, dn_d;
  logic [17:0] tick_q, tick_d;
  logic [8:0] dur_q, dur_d;
  pulse_t ps_q, ps_d;

  logic [16:0] lim_main, lim_latch;
  logic signed [32:0] hyst_s;
  logic a, b, g, l, a_r, b_r, g_r, l_r, a_p, b_p;
  logic soft_gate_bit, gate_en, step, up;
  logic signed [32:0] next_cnt;
  logic signed [32:0] diff;
  logic [7:0] hyst;
  logic ge_c, le_c, eq_c, cmp_raw, oflw, uflw;
  char_t ch;
  eval_t ev_mode;

  // The 1 kHz limit needs 17 bits at this clock.
  function automatic logic [16:0] lim_of(input logic [1:0] sel);
    case (sel)
      2'h0:    lim_of = 17'(FLT10_CYC);
      2'h1:    lim_of = 17'(FLT5_CYC);
      2'h2:    lim_of = 17'(FLT2_CYC);
      default: lim_of = 17'(FLT1_CYC);
    endcase
  endfunction

  assign lim_main  = lim_of(cfg_q[CFG_FREQ_LSB +: 2]);  // [RULE_02]
  assign lim_latch = lim_of(cfg_q[CFG_LFREQ_LSB +: 2]); // [RULE_03]

  // A level change is accepted only after it has stood for the limit count.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      fcnt_d[i] = 17'h00000;
      flt_d[i]  = flt_q[i];
      if (sync2_q[i] != flt_q[i])
      begin
        fcnt_d[i] = fcnt_q[i] + 17'h00001;
        if (fcnt_q[i] + 17'h00001 >= ((i == 3) ? lim_latch : lim_main)) // [RULE_24]
        begin
          flt_d[i]  = sync2_q[i];
          fcnt_d[i] = 17'h00000;
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sync1_q    <= 4'h0;
      sync2_q    <= 4'h0;
      flt_q      <= 4'h0;
      flt_prev_q <= 4'h0;
      for (int i = 0; i < 4; i++)
        fcnt_q[i] <= 17'h00000;
    end
    else
    begin
      sync1_q    <= {latch_i, pin_gate_i, track_b_i, track_a_i};
      sync2_q    <= sync1_q;
      flt_q      <= flt_d;
      flt_prev_q <= flt_q;
      for (int i = 0; i < 4; i++)
        fcnt_q[i] <= fcnt_d[i];
    end
  end

  assign {l, g, b, a}         = flt_q;
  assign {l_r, g_r, b_r, a_r} = flt_q & ~flt_prev_q;
  assign a_p = flt_prev_q[0];
  assign b_p = flt_prev_q[1];
  assign soft_gate_bit = ctrl_q[CTRL_SOFT_GATE]; // [RULE_15]
  // Pin gate level is its edge-opened state: rises open, falls close.
  assign gate_en = soft_gate_bit & (~cfg_q[CFG_PIN_COUNT_GATE] | g); // [RULE_05] [RULE_19] [RULE_20]
  assign ev_mode = eval_t'(cfg_q[CFG_EVAL_LSB +: 2]);
  assign ch      = char_t'(cfg_q[CFG_CHAR_LSB +: 2]);
  assign hyst    = cfg_q[CFG_HYST_LSB +: 8];
  // Signed copy so the band compares correctly on both sides of zero.
  assign hyst_s  = $signed({25'h0000000, hyst});

  // Edge decoding of the count inputs.
  always_comb
  begin
    step = 1'b0;
    up   = 1'b1;
    case (ev_mode) // [RULE_04]
      EVAL_PULSE:
      begin
        step = a_r;
        up   = ~(b ^ cfg_q[CFG_DIR_INV]); // [RULE_06]
      end
      EVAL_X1:
      begin
        step = (a & ~a_p & ~b) | (~a & a_p & ~b);
        up   = a;
      end
      EVAL_X2:
      begin
        step = a ^ a_p;
        up   = a ^ b;
      end
      default:
      begin
        step = (a ^ a_p) | (b ^ b_p);
        up   = (a ^ a_p) ? (a ^ b) : ~(a ^ b);
      end
    endcase
    if (ev_mode != EVAL_PULSE)
      up = up ^ cfg_q[CFG_DIR_INV]; // [RULE_06]
  end

  assign next_cnt = up ? 33'(count_q) + 33'sd1 : 33'(count_q) - 33'sd1;
  assign oflw = step & gate_en & up & (count_q == 32'sh7FFF_FFFF);
  assign uflw = step & gate_en & ~up & (count_q == 32'sh8000_0000);
  assign diff = 33'(count_q) - 33'($signed(cmp_q));
  assign eq_c = count_q == $signed(cmp_q);
  // Hysteresis widens the switching point once the output is set.
  always_comb
  begin
    ge_c = diff >= 33'sd0;
    le_c = diff <= 33'sd0;
    if (hyst > 8'h01 && out_q) // [RULE_01] [RULE_23]
    begin
      ge_c = diff >= -hyst_s;
      le_c = diff <= hyst_s;
    end
    case (ch) // [RULE_07]
      CH_GE:   cmp_raw = ge_c;
      CH_LE:   cmp_raw = le_c;
      CH_PULSE: cmp_raw = eq_c;
      default: cmp_raw = 1'b0;
    endcase
  end

  // Counter, latch, pulse timer and comparator output.
  always_comb
  begin
    count_d = count_q;
    latch_d = latch_q;
    up_d    = up_q;
    dn_d    = dn_q;
    tick_d  = tick_q;
    dur_d   = dur_q;
    ps_d    = ps_q;
    out_d   = out_q;
    hit_d   = hit_q;
    if (step && gate_en)
    begin
      count_d = next_cnt[31:0];
      up_d    = up;
      dn_d    = ~up;
    end
    if (l_r)
      latch_d = count_q; // [RULE_22]
    case (ps_q)
      PS_IDLE:
      begin
        if (ch == CH_PULSE && eq_c && dur_q != 9'h000)
        begin
          ps_d   = PS_HOLD;
          tick_d = 18'h00000;
          dur_d  = 9'h000;
        end
      end
      PS_HOLD:
      begin
        tick_d = tick_q + 18'h00001;
        if (tick_q == 18'(TICK_CYC_P - 1))
        begin
          tick_d = 18'h00000;
          dur_d  = dur_q + 9'h001;
          if (dur_q + 9'h001 >= {cfg_q[CFG_DUR_LSB +: 8], 1'b0}) // [RULE_08]
            ps_d = PS_DONE;
        end
      end
      PS_DONE:
        if (!eq_c)
          ps_d = PS_IDLE;
      default: ps_d = PS_IDLE;
    endcase
    if (ch == CH_PULSE && ps_d == PS_IDLE)
      dur_d = {cfg_q[CFG_DUR_LSB +: 8], 1'b0}; // [RULE_08]
    if (!ctrl_q[CTRL_CMP_EN])
      out_d = ctrl_q[CTRL_PLAIN_OUT]; // [RULE_16]
    else if (ch == CH_PULSE && cfg_q[CFG_DUR_LSB +: 8] == 8'h00)
      out_d = eq_c; // [RULE_21]
    else if (ch == CH_PULSE)
      out_d = ps_q == PS_HOLD;
    else
      out_d = cmp_raw; // [RULE_07]
    hit_d = (ch != CH_NONE) & cmp_raw;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_q <= 32'sh0000_0000;
      latch_q <= 32'sh0000_0000;
      up_q    <= 1'b0;
      dn_q    <= 1'b0;
      tick_q  <= 18'h00000;
      dur_q   <= 9'h000;
      ps_q    <= PS_IDLE;
      out_q   <= 1'b0;
      hit_q   <= 1'b0;
    end
    else
    begin
      count_q <= (wr_i && addr_i == REG_COUNT) ? $signed(wdata_i) : count_d; // [RULE_18]
      latch_q <= latch_d;
      up_q    <= up_d;
      dn_q    <= dn_d;
      tick_q  <= tick_d;
      dur_q   <= dur_d;
      ps_q    <= ps_d;
      out_q   <= out_d;
      hit_q   <= hit_d;
    end
  end

  // Sticky events; a new event in the clearing cycle wins over the clear.
  always_comb
  begin
    ev_d = ev_q;
    if (wr_i && addr_i == REG_EVENT)
      ev_d = ev_q & ~wdata_i[4:0];
    if (cfg_q[CFG_IRQ_OPEN] && g_r && soft_gate_bit)
      ev_d[EV_OPEN] = 1'b1; // [RULE_09]
    if (cfg_q[CFG_IRQ_CLOSE] && !g && flt_prev_q[2] && soft_gate_bit)
      ev_d[EV_CLOSE] = 1'b1; // [RULE_10]
    if (cfg_q[CFG_IRQ_CMP] && ch != CH_NONE && hit_d && !hit_q)
      ev_d[EV_CMP] = 1'b1; // [RULE_11] [RULE_12]
    if (cfg_q[CFG_IRQ_OFLW] && oflw)
      ev_d[EV_OFLW] = 1'b1; // [RULE_13]
    if (cfg_q[CFG_IRQ_UFLW] && uflw)
      ev_d[EV_UFLW] = 1'b1; // [RULE_14]
  end

  // Register port.
  always_comb
  begin
    ctrl_d  = ctrl_q;
    cfg_d   = cfg_q;
    cmp_d   = cmp_q;
    rdata_d = '0;
    if (wr_i) // [RULE_18]
    begin
      case (addr_i)
        REG_CTRL: ctrl_d = {29'h0, wdata_i[2:0]};
        REG_CFG:  cfg_d  = {wdata_i[31:16], 1'b0, wdata_i[14:0]};
        REG_CMP:  cmp_d  = wdata_i;
        default:  ctrl_d = ctrl_q;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        REG_CTRL:   rdata_d = ctrl_q;
        REG_CFG:    rdata_d = cfg_q;
        REG_CMP:    rdata_d = cmp_q;
        REG_COUNT:  rdata_d = count_q; // [RULE_17]
        REG_LATCH:  rdata_d = latch_q; // [RULE_17]
        REG_STATUS: rdata_d = {25'h0, dn_q, up_q, hit_q, out_q, l, g, gate_en};
        REG_EVENT:  rdata_d = {27'h0, ev_q};
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_q      <= 32'h0000_0000;
      cfg_q       <= CFG_RESET;
      cmp_q       <= 32'h0000_0000;
      ev_q        <= 5'h00;
      rdata_o     <= 32'h0000_0000;
      count_out_o <= 1'b0;
      event_o     <= 1'b0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      cfg_q       <= cfg_d;
      cmp_q       <= cmp_d;
      ev_q        <= ev_d;
      rdata_o     <= rdata_d;
      count_out_o <= out_d;
      event_o     <= |ev_d;
    end
  end

  a_gate_blocks_count: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_05]
    !gate_en && !(wr_i && addr_i == REG_COUNT) |=> count_q == $past(count_q))
    else $error("count moved while gate closed");
  a_latch_capture: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_22]
    l_r |=> latch_q == $past(count_q))
    else $error("latch did not capture count");
  a_plain_output: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_16]
    !ctrl_q[CTRL_CMP_EN] |=> count_out_o == $past(ctrl_q[CTRL_PLAIN_OUT]))
    else $error("plain output not followed");
  a_cmp_suppress: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_12]
    ch == CH_NONE && !ev_q[EV_CMP] && !(wr_i && addr_i == REG_EVENT) |=> !ev_q[EV_CMP])
    else $error("compare event without comparison mode");
  a_oflw_event: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_13]
    oflw && cfg_q[CFG_IRQ_OFLW] |=> ev_q[EV_OFLW] && event_o)
    else $error("overflow event missing");
  a_open_event: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_09]
    g_r && soft_gate_bit && cfg_q[CFG_IRQ_OPEN] |=> ev_q[EV_OPEN])
    else $error("gate open event missing");
  a_count_read: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_17]
    rd_i && addr_i == REG_COUNT |=> rdata_o == $past(count_q))
    else $error("count read wrong");
  a_ge_output: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE_07]
    ctrl_q[CTRL_CMP_EN] && ch == CH_GE && hyst < 8'h02 |=> out_q == ($past(diff) >= 33'sd0))
    else $error("at-or-above output wrong");
endmodule

// *** verif/gated_counter_test.sv ***
// Self-checking bench for the gated counter channel.
`timescale 1ns/1ps
module gated_counter_test;
  import counter_pkg::*;
  typedef struct {logic [3:0] addr; logic [31:0] data; logic out;} row_t;
  logic        mclk_i          = 1'b0;
  logic        reset_i         = 1'b1;
  localparam int TICK_SIM      = 204;
  logic        latch_i         = 1'b0;
  logic        pin_gate_i      = 1'b0;
  logic        wr_i            = 1'b0;
  logic        rd_i            = 1'b0;
  logic [3:0]  addr_i          = 4'h0;
  logic [31:0] wdata_i         = 32'h0;
  logic [31:0] rdata_o;
  logic        track_a;
  logic        track_b;
  logic        count_out_o;
  logic        event_o;
  logic [31:0] v;
  int          n;
  int          fail_count      = 0;
  int          samples_checked = 0;
  logic [3:0]  zero_regs [6];
  row_t        rows [16];

  always #2.5 mclk_i = ~mclk_i;

  pulse_source i_gen (.mclk_i(mclk_i), .track_a_o(track_a), .track_b_o(track_b));

  // A short time unit keeps the pulse test inside the cycle budget.
  gated_counter #(.TICK_CYC_P(TICK_SIM)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .track_a_i(track_a), .track_b_i(track_b),
    .pin_gate_i(pin_gate_i), .latch_i(latch_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_out_o(count_out_o),
    .event_o(event_o));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // A wait that runs out ends the run, so a hung output never stalls it.
  task automatic wait_out(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (count_out_o !== lvl && cnt < bound)
    begin
      @(posedge mclk_i);
      #1;
      cnt++;
    end
    if (count_out_o !== lvl)
    begin
      fail_count++;
      $display("MISMATCH count_out_o expected %b seen %b", lvl, count_out_o);
      summarize();
    end
  endtask

  initial
  begin
    zero_regs = '{REG_CFG, REG_COUNT, REG_LATCH, REG_STATUS, REG_EVENT, 4'hF};
    rows = '{'{REG_CTRL, 32'h4, 1'b1}, '{REG_CFG, 32'h100, 1'b1}, '{REG_CMP, 32'hA, 1'b1},
             '{REG_CTRL, 32'h2, 1'b0}, '{REG_COUNT, 32'hA, 1'b1}, '{REG_COUNT, 32'h9, 1'b0},
             '{REG_CFG, 32'h200, 1'b1}, '{REG_COUNT, 32'hB, 1'b0},
             '{REG_CFG, 32'h0005_0100, 1'b1}, '{REG_CMP, 32'h64, 1'b0},
             '{REG_COUNT, 32'h64, 1'b1}, '{REG_COUNT, 32'h61, 1'b1},
             '{REG_COUNT, 32'h5E, 1'b0}, '{REG_CFG, 32'h300, 1'b0},
             '{REG_COUNT, 32'h64, 1'b1}, '{REG_COUNT, 32'h65, 1'b0}};
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (zero_regs[i])
    begin
      reg_rd(zero_regs[i], v);
      check_word("reset_read", 32'h0, v);
    end
    check_bit("event_o", 1'b0, event_o);
    reg_wr(REG_CMP, 32'hFFFF_FFF6);
    reg_rd(REG_CMP, v);
    check_word("cmp_readback", 32'hFFFF_FFF6, v);
    foreach (rows[i])
    begin
      reg_wr(rows[i].addr, rows[i].data);
      repeat (4) @(posedge mclk_i);
      #1;
      check_bit("out", rows[i].out, count_out_o);
    end
    // Pulse mode with a duration of 2 units of TICK_SIM cycles.
    reg_wr(REG_CFG, 32'h0100_0300);
    reg_wr(REG_COUNT, 32'h63);
    reg_wr(REG_COUNT, 32'h64);
    wait_out(1'b1, 10, n);
    wait_out(1'b0, 1000, n);
    check_bit("pulse_len", 1'b1, 1'(n > TICK_SIM && n <= 2 * TICK_SIM + 4));
    // Counting through the filtered pins, with the compare event.
    reg_wr(REG_CTRL, 32'h3);
    reg_wr(REG_CFG, 32'h1100);
    reg_wr(REG_CMP, 32'h1);
    reg_wr(REG_COUNT, 32'h0);
    reg_wr(REG_EVENT, 32'h1F);
    i_gen.step(1'b0, FLT10_CYC + 100, FLT10_CYC + 100);
    reg_rd(REG_COUNT, v);
    check_word("count_up", 32'h1, v);
    check_bit("event_o", 1'b1, event_o);
    reg_rd(REG_EVENT, v);
    check_bit("cmp_event", 1'b1, v[EV_CMP]);
    reg_wr(REG_EVENT, 32'h1F);
    reg_wr(REG_CFG, 32'h1080);
    reg_wr(REG_CMP, 32'h0);
    i_gen.step(1'b0, FLT10_CYC + 100, FLT10_CYC + 100);
    reg_rd(REG_COUNT, v);
    check_word("count_inverted", 32'h0, v);
    check_bit("event_o", 1'b0, event_o);
    reg_wr(REG_CTRL, 32'h0);
    i_gen.step(1'b0, FLT10_CYC + 100, FLT10_CYC + 100);
    reg_rd(REG_COUNT, v);
    check_word("count_gate_shut", 32'h0, v);
    reg_wr(REG_CTRL, 32'h1);
    i_gen.step(1'b0, FLT10_CYC / 5, FLT10_CYC / 5);
    reg_rd(REG_COUNT, v);
    check_word("count_glitch", 32'h0, v);
    reg_wr(REG_COUNT, 32'h1234);
    reg_wr(REG_CFG, 32'h0000_0440);
    reg_wr(REG_EVENT, 32'h1F);
    @(posedge mclk_i);
    latch_i    <= 1'b1;
    pin_gate_i <= 1'b1;
    repeat (FLT10_CYC + 100) @(posedge mclk_i);
    reg_rd(REG_STATUS, v);
    check_word("status_gates", 32'h7, {29'h0, v[2:0]});
    reg_rd(REG_EVENT, v);
    check_bit("open_event", 1'b1, v[EV_OPEN]);
    latch_i <= 1'b0;
    reg_rd(REG_LATCH, v);
    check_word("latch", 32'h1234, v);
    summarize();
  end
endmodule

// *** verif/pulse_source.sv ***
// Pulse generator with a direction level, standing in for the field encoder.
`timescale 1ns/1ps
module pulse_source
(
  // Clock
  input  wire logic mclk_i,
  // Field side
  output logic      track_a_o,
  output logic      track_b_o
);
  initial
  begin
    track_a_o = 1'b0;
    track_b_o = 1'b0;
  end

  // Direction is set up before the pulse and held through it. Both lines
  // pass the same filter, so the direction reaches the counter first.
  task automatic step(input logic down, input int hi_cyc, input int lo_cyc);
    @(posedge mclk_i);
    track_b_o <= down;
    repeat (8) @(posedge mclk_i);
    track_a_o <= 1'b1;
    repeat (hi_cyc) @(posedge mclk_i);
    track_a_o <= 1'b0;
    repeat (lo_cyc) @(posedge mclk_i);
  endtask
endmodule
